// file: shared/black_cal_pkg.sv
// =====================================================================
// Shared constants and carriers for the black level calibration loop.
// =====================================================================
package black_cal_pkg;

    // =================================================================
    // Widths
    // =================================================================
    localparam int PIX_W    = 10;               // Converter word width.
    localparam int ACC_W    = 16;               // Holds 64 full-scale words.
    localparam int FRAC_W   = 7;                // Filter fraction bits, 1/128.
    localparam int EST_W    = PIX_W + FRAC_W;
    localparam int COARSE_W = 8;
    localparam int FINE_W   = 9;                // Direct writes reach -256 to +255.
    localparam int GAIN_W   = 10;               // Gain code width.
    localparam int GLIN_W   = 10;               // Linear gain, 4 fraction bits.
    localparam int GLIN_FRAC = 4;
    localparam int STEP_W   = GLIN_W + 3;       // Step size times two.
    localparam int ERR_W    = 12;

    // =================================================================
    // Reset values, limits and thresholds
    // =================================================================
    localparam logic [PIX_W-1:0]  TARGET_RST  = 10'h040;
    localparam logic [ERR_W-1:0]  FINE_LIMIT  = 12'h07f;
    localparam logic [2:0]        COUNT_N_MAX = 3'h6;
    localparam logic [GAIN_W-1:0] GAIN_EDGE_A = 10'h040;
    localparam logic [GAIN_W-1:0] GAIN_EDGE_B = 10'h060;
    localparam logic [GAIN_W-1:0] GAIN_EDGE_C = 10'h080;
    localparam logic [2:0]        STEP_N2_A   = 3'h4;     // n = 2.
    localparam logic [2:0]        STEP_N2_B   = 3'h3;     // n = 1.5.
    localparam logic [2:0]        STEP_N2_C   = 3'h2;     // n = 1.
    localparam logic [2:0]        STEP_N2_D   = 3'h1;     // n = 0.5.
    localparam int                FIFO_DEPTH  = 4;

    // =================================================================
    // Types
    // =================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACC  = 3'b001,
        ST_FILT = 3'b010,
        ST_LOOP = 3'b011,
        ST_SKIP = 3'b100
    } cal_state_t;

    // One converter word with its line and frame tags.
    typedef struct packed {
        logic             frame_start;
        logic             black;
        logic [PIX_W-1:0] data;
    } pix_t;

    // Offset DAC codes as driven to the analog front end.
    typedef struct packed {
        logic [COARSE_W-1:0] coarse;
        logic [FINE_W-1:0]   fine;
    } dac_t;

endpackage

// file: rtl/black_cal.sv
`timescale 1ns/1ps

// =====================================================================
// Word FIFO between the converter stream and the calibration loop.
// =====================================================================
module pix_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // Filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Draining side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t d;
    logic        push;
    logic        pop;

    // Full and empty follow the occupancy count directly.
    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update.
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = in_data;
            d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
        end
        if (pop)
        begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            q <= '0;
        else
            q <= d;
    end
endmodule

// =====================================================================
// Optical black and offset calibration loop.
// =====================================================================
module black_cal #(
    parameter int FIFO_DEPTH = black_cal_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  sys_rst,
    // Converter stream and line timing
    input  wire logic                                  pix_valid,
    input  wire logic [black_cal_pkg::PIX_W-1:0]       pixel_output_word,
    input  wire logic                                  black_clamp_pulse_n,
    input  wire logic                                  frame_start,
    output logic                                       pix_ready,
    // Gain setting
    input  wire logic [black_cal_pkg::GAIN_W-1:0]      gain_code,
    input  wire logic [black_cal_pkg::GLIN_W-1:0]      gain_linear,
    // Loop configuration
    input  wire logic [black_cal_pkg::PIX_W-1:0]       hot_limit,
    input  wire logic [black_cal_pkg::PIX_W-1:0]       cold_limit,
    input  wire logic [2:0]                            weight_shift,
    input  wire logic [2:0]                            count_log2,
    input  wire logic                                  sof_fast_en,
    input  wire logic                                  target_load,
    input  wire logic [black_cal_pkg::PIX_W-1:0]       target_value,
    // Direct programming
    input  wire logic                                  direct_mode,
    input  wire logic                                  coarse_wr,
    input  wire logic                                  fine_wr,
    input  wire logic [black_cal_pkg::FINE_W-1:0]      dac_wr_data,
    // Results
    output black_cal_pkg::dac_t                        offset_dac,
    output logic [black_cal_pkg::PIX_W-1:0]            black_estimate,
    output logic [black_cal_pkg::PIX_W-1:0]            black_target_level,
    output logic [black_cal_pkg::STEP_W-1:0]           coarse_step_x2
);
    typedef struct packed {
        black_cal_pkg::cal_state_t                 st;
        logic [black_cal_pkg::ACC_W-1:0]           acc;
        logic [6:0]                                cnt;
        logic [black_cal_pkg::PIX_W-1:0]           prev;
        logic [black_cal_pkg::EST_W-1:0]           est;
        logic                                      first;
        logic [black_cal_pkg::PIX_W-1:0]           target;
        logic [black_cal_pkg::STEP_W-1:0]          step;
        black_cal_pkg::dac_t                       dac;
    } cal_t;

    cal_t                                 q;
    cal_t                                 d;
    black_cal_pkg::pix_t                  in_word;
    black_cal_pkg::pix_t                  w;
    logic                                 w_valid;
    logic                                 take;
    logic [2:0]                           n_eff;
    logic [6:0]                           n_pix;
    logic                                 line_first;
    logic                                 limits_on;
    logic                                 out_of_range;
    logic [black_cal_pkg::PIX_W-1:0]      used;
    logic [black_cal_pkg::PIX_W-1:0]      line_avg;
    logic [2:0]                           k;
    logic signed [black_cal_pkg::EST_W+1:0] delta;
    logic signed [black_cal_pkg::ERR_W-1:0] err;
    logic signed [black_cal_pkg::ERR_W-1:0] fine_tgt;
    logic signed [black_cal_pkg::ERR_W-1:0] step_lsb;
    logic [2:0]                           n2;

    // =================================================================
    // Input buffer
    // =================================================================
    // clamp tags black
    assign in_word = '{frame_start: frame_start, black: !black_clamp_pulse_n, data: pixel_output_word};

    pix_fifo #(
        .W     ($bits(black_cal_pkg::pix_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (pix_valid),
        .in_data   (in_word),
        .in_ready  (pix_ready),
        .out_valid (w_valid),
        .out_data  (w),
        .out_ready (take)
    );

    // The loop stalls the buffer while it filters and steps the DACs.
    assign take = w_valid && (q.st != black_cal_pkg::ST_FILT) && (q.st != black_cal_pkg::ST_LOOP);

    // =================================================================
    // Per-pixel datapath
    // =================================================================
    // count clamped
    assign n_eff = (count_log2 > black_cal_pkg::COUNT_N_MAX) ? black_cal_pkg::COUNT_N_MAX : count_log2;
    assign n_pix = 7'(1) << n_eff;
    assign line_first = q.first || w.frame_start;
    assign limits_on = !(sof_fast_en && line_first);
    assign out_of_range = (w.data > hot_limit) || (w.data < cold_limit);
    assign used = (limits_on && out_of_range) ? q.prev : w.data;
    assign line_avg = black_cal_pkg::PIX_W'(q.acc >> n_eff);
    assign k = (sof_fast_en && q.first) ? 3'h0 : weight_shift;
    assign delta = $signed({2'b00, line_avg, black_cal_pkg::FRAC_W'(0)}) - $signed({2'b00, q.est});
    assign err = $signed({2'b00, q.est[black_cal_pkg::EST_W-1:black_cal_pkg::FRAC_W]})
               - $signed({2'b00, q.target});
    assign fine_tgt = $signed({{(black_cal_pkg::ERR_W-black_cal_pkg::FINE_W){q.dac.fine[8]}}, q.dac.fine}) - err;
    assign step_lsb = $signed(black_cal_pkg::ERR_W'(q.step >> (black_cal_pkg::GLIN_FRAC + 1)));

    always_comb
    begin
        if (gain_code < black_cal_pkg::GAIN_EDGE_A)
            n2 = black_cal_pkg::STEP_N2_A;
        else if (gain_code < black_cal_pkg::GAIN_EDGE_B)
            n2 = black_cal_pkg::STEP_N2_B;
        else if (gain_code < black_cal_pkg::GAIN_EDGE_C)
            n2 = black_cal_pkg::STEP_N2_C;
        else
            n2 = black_cal_pkg::STEP_N2_D;
    end

    // =================================================================
    // Control loop
    // =================================================================
    // Clamps the fine correction into its +/-127 automatic range.
    function automatic logic [black_cal_pkg::FINE_W-1:0] fine_clamp(
        input logic signed [black_cal_pkg::ERR_W-1:0] v
    );
        if (v > $signed(black_cal_pkg::FINE_LIMIT))
            return black_cal_pkg::FINE_W'(black_cal_pkg::FINE_LIMIT);
        else if (v < -$signed(black_cal_pkg::FINE_LIMIT))
            return black_cal_pkg::FINE_W'(-$signed(black_cal_pkg::FINE_LIMIT));
        else
            return black_cal_pkg::FINE_W'(v);
    endfunction

    // Next-state logic for sequencing, filter and DAC codes.
    always_comb
    begin
        d = q;
        d.step = black_cal_pkg::STEP_W'(gain_linear) * black_cal_pkg::STEP_W'(n2);
        if (target_load)
            d.target = target_value;
        if (direct_mode && coarse_wr)
            d.dac.coarse = dac_wr_data[black_cal_pkg::COARSE_W-1:0];
        if (direct_mode && fine_wr)
            d.dac.fine = dac_wr_data;
        if (take && w.frame_start)
            d.first = 1'b1;
        case (q.st)
            black_cal_pkg::ST_IDLE, black_cal_pkg::ST_ACC:
            begin
                if (take && w.black)
                begin
                    d.acc  = q.acc + black_cal_pkg::ACC_W'(used);
                    d.cnt  = q.cnt + 7'h01;
                    d.prev = used;
                    d.st = (q.cnt + 7'h01 == n_pix) ? black_cal_pkg::ST_FILT : black_cal_pkg::ST_ACC;
                end
                else if (take)
                begin
                    d.acc = '0;
                    d.cnt = '0;
                    d.st  = black_cal_pkg::ST_IDLE;
                end
            end
            black_cal_pkg::ST_FILT:
            begin
                d.est = black_cal_pkg::EST_W'($unsigned($signed({2'b00, q.est}) + (delta >>> k)));
                d.acc = '0;
                d.cnt = '0;
                d.st  = black_cal_pkg::ST_LOOP;
            end
            black_cal_pkg::ST_LOOP:
            begin
                if (!direct_mode)
                begin
                    if (fine_tgt > $signed(black_cal_pkg::FINE_LIMIT))
                    begin
                        d.dac.coarse = q.dac.coarse + black_cal_pkg::COARSE_W'(1);
                        d.dac.fine = fine_clamp(fine_tgt - step_lsb);
                    end
                    else if (fine_tgt < -$signed(black_cal_pkg::FINE_LIMIT))
                    begin
                        d.dac.coarse = q.dac.coarse - black_cal_pkg::COARSE_W'(1);
                        d.dac.fine = fine_clamp(fine_tgt + step_lsb);
                    end
                    else
                    begin
                        d.dac.fine = fine_clamp(fine_tgt);
                    end
                end
                d.first = 1'b0;
                d.st    = black_cal_pkg::ST_SKIP;
            end
            black_cal_pkg::ST_SKIP:
            begin
                if (take && !w.black)
                    d.st = black_cal_pkg::ST_IDLE;
            end
            default:
            begin
                d.st = black_cal_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q        <= '0;
            q.st     <= black_cal_pkg::ST_IDLE;
            q.target <= black_cal_pkg::TARGET_RST;
            q.prev   <= black_cal_pkg::TARGET_RST;
            q.est    <= {black_cal_pkg::TARGET_RST, black_cal_pkg::FRAC_W'(0)};
        end
        else
            q <= d;
    end

    // Registered results.
    assign offset_dac         = q.dac;
    assign black_estimate     = q.est[black_cal_pkg::EST_W-1:black_cal_pkg::FRAC_W];
    assign black_target_level = q.target;
    assign coarse_step_x2     = q.step;

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_FINE_RANGE: assert property (q.st == black_cal_pkg::ST_LOOP && !direct_mode |=>
        $signed(q.dac.fine) <= 127 && $signed(q.dac.fine) >= -127)
        else $error("Fine code left its automatic range.");
    AST_COARSE_STEP: assert property (!direct_mode |=>
        ($signed(q.dac.coarse - $past(q.dac.coarse)) inside {-1, 0, 1}))
        else $error("Coarse code moved by more than one step.");
    AST_DIRECT_WR: assert property (direct_mode && coarse_wr |=>
        q.dac.coarse == $past(dac_wr_data[7:0]))
        else $error("Direct coarse write was not taken.");
    AST_DIRECT_HOLD: assert property (direct_mode && !coarse_wr && !fine_wr |=> $stable(q.dac))
        else $error("DAC codes moved in direct mode.");
    AST_TARGET_HOLD: assert property (!target_load |=> $stable(q.target))
        else $error("Target changed without a load.");
    AST_SUBST: assert property (take && w.black && limits_on && out_of_range
        && (q.st == black_cal_pkg::ST_IDLE || q.st == black_cal_pkg::ST_ACC) |=> $stable(q.prev))
        else $error("Out-of-limit pixel was not replaced.");
    AST_SOF_WEIGHT: assert property (q.st == black_cal_pkg::ST_FILT && sof_fast_en && q.first |=>
        q.est == {$past(line_avg), 7'h00})
        else $error("Fast frame start did not load the line average.");
    AST_COUNT: assert property (q.st == black_cal_pkg::ST_FILT |-> q.cnt == n_pix)
        else $error("Update without a full pixel count.");
    AST_ONE_UPDATE: assert property (q.st == black_cal_pkg::ST_FILT |=>
        q.st == black_cal_pkg::ST_LOOP ##1 q.st == black_cal_pkg::ST_SKIP)
        else $error("Update sequence broken.");

    COV_COARSE: cover property (q.st == black_cal_pkg::ST_LOOP ##1 $changed(q.dac.coarse));
    COV_SUBST: cover property (take && w.black && limits_on && out_of_range);
    COV_SOF: cover property (q.st == black_cal_pkg::ST_FILT && sof_fast_en && q.first);
    COV_FULL: cover property (pix_valid && !pix_ready);
endmodule

// file: tb/ccd_line_model.sv
`timescale 1ns/1ps

// =====================================================================
// Sensor timing source: a black run under the clamp pulse, one active word.
// =====================================================================
module ccd_line_model (
    // Clock and flow control
    input  wire logic                       clk_sys,
    input  wire logic                       pix_ready,
    // Word stream
    output logic                            pix_valid,
    output logic [black_cal_pkg::PIX_W-1:0] pixel_output_word,
    output logic                            black_clamp_pulse_n,
    output logic                            frame_start,
    output logic                            stalled
);
    // Starts idle with no word offered.
    initial
    begin
        pix_valid = 1'b0;
        pixel_output_word = 10'h155;
        black_clamp_pulse_n = 1'b1;
        frame_start = 1'b0;
        stalled = 1'b0;
    end

    // Holds one word steady until the edge that takes it.
    task automatic put(input logic [9:0] d, input logic blk, input logic sof);
        int i;
        logic acc;
        acc = 1'b0;
        pix_valid = 1'b1;
        pixel_output_word = d;
        black_clamp_pulse_n = ~blk;
        frame_start = sof;
        for (i = 0; i < 50 && !acc; i++)
        begin
            acc = (pix_ready === 1'b1);
            @(posedge clk_sys);
            #1;
        end
        if (!acc)
            stalled = 1'b1;
    endtask

    // Released data shows the inverse of the last word.
    task automatic drop();
        pix_valid = 1'b0;
        pixel_output_word = ~pixel_output_word;
        black_clamp_pulse_n = 1'b1;
        frame_start = 1'b0;
    endtask

    // Sends cnt black words, a first and b for the rest, optionally spaced, then an active word.
    task automatic line(input logic [9:0] a, input logic [9:0] b, input int cnt, input logic sof,
                        input int gap);
        for (int k = 0; k < cnt; k++)
        begin
            put((k == 0) ? a : b, 1'b1, sof && (k == 0));
            if (gap > 0)
            begin
                drop();
                repeat (gap) @(posedge clk_sys);
                #1;
            end
        end
        put(10'h200, 1'b0, 1'b0);
        drop();
    endtask
endmodule

// file: tb/black_cal_test.sv
`timescale 1ns/1ps

// =====================================================================
// Self-checking bench for the black level calibration loop.
// =====================================================================
module black_cal_test;
    logic                clk_sys = 1'b0;
    logic                sys_rst = 1'b1;
    logic                pix_valid, black_clamp_pulse_n, frame_start, pix_ready, stalled;
    logic [9:0]          pixel_output_word, black_estimate, black_target_level;
    logic [9:0]          gain_code = 10'h000, gain_linear = 10'h010, target_value = 10'h000;
    logic [9:0]          hot_limit = 10'h3ff, cold_limit = 10'h000;
    logic [2:0]          weight_shift = 3'h0, count_log2 = 3'h0;
    logic                sof_fast_en = 1'b0, target_load = 1'b0, direct_mode = 1'b0;
    logic                coarse_wr = 1'b0, fine_wr = 1'b0;
    logic [8:0]          dac_wr_data = 9'h000;
    logic [12:0]         coarse_step_x2;
    black_cal_pkg::dac_t offset_dac;
    int                  err_total = 0;
    int                  samples_checked = 0;

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    black_cal #(.FIFO_DEPTH(black_cal_pkg::FIFO_DEPTH)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pix_valid(pix_valid),
        .pixel_output_word(pixel_output_word), .black_clamp_pulse_n(black_clamp_pulse_n),
        .frame_start(frame_start), .pix_ready(pix_ready), .gain_code(gain_code),
        .gain_linear(gain_linear), .hot_limit(hot_limit), .cold_limit(cold_limit),
        .weight_shift(weight_shift), .count_log2(count_log2), .sof_fast_en(sof_fast_en),
        .target_load(target_load), .target_value(target_value), .direct_mode(direct_mode),
        .coarse_wr(coarse_wr), .fine_wr(fine_wr), .dac_wr_data(dac_wr_data),
        .offset_dac(offset_dac), .black_estimate(black_estimate),
        .black_target_level(black_target_level), .coarse_step_x2(coarse_step_x2));

    ccd_line_model ccd_u (
        .clk_sys(clk_sys), .pix_ready(pix_ready), .pix_valid(pix_valid),
        .pixel_output_word(pixel_output_word), .black_clamp_pulse_n(black_clamp_pulse_n),
        .frame_start(frame_start), .stalled(stalled));

    // Prints the verdict and ends the run.
    task automatic results();
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Compares one plain value.
    task automatic check_val(input string nm, input logic [15:0] ev, input logic [15:0] gv);
        samples_checked++;
        if (gv !== ev)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, gv);
        end
    endtask

    // Compares both offset DAC codes.
    task automatic check_dac(input black_cal_pkg::dac_t ev);
        samples_checked++;
        if (offset_dac !== ev)
        begin
            err_total++;
            $display("CHECK FAILED offset_dac expected %h seen %h", ev, offset_dac);
        end
    endtask

    // Moves to just after the next rising edge.
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    // Waits a bounded time for the line update, then lets the DAC update land.
    task automatic done(input logic [9:0] ev);
        int i;
        for (i = 0; i < 40 && black_estimate !== ev; i++)
            step();
        step();
        step();
        check_val("black_estimate", 16'(ev), 16'(black_estimate));
        if (i == 40 || stalled)
        begin
            err_total++;
            results();
        end
    endtask

    // Values seen straight after reset.
    task automatic reset_check();
        check_dac('0);
        check_val("black_target_level", 16'h0040, 16'(black_target_level));
        check_val("black_estimate", 16'h0040, 16'(black_estimate));
        check_val("pix_ready", 16'h0001, 16'(pix_ready));
    endtask

    // Coarse step size on both sides of every gain band edge.
    task automatic gain_check();
        logic [9:0]  codes [6] = '{10'h03f, 10'h040, 10'h05f, 10'h060, 10'h07f, 10'h080};
        logic [12:0] steps [6] = '{13'h0040, 13'h0030, 13'h0030, 13'h0020, 13'h0020, 13'h0010};
        for (int i = 0; i < 6; i++)
        begin
            gain_code = codes[i];
            step();
            step();
            check_val("coarse_step_x2", 16'(steps[i]), 16'(coarse_step_x2));
        end
    endtask

    // A fine write is ignored outside direct mode; both writes are taken inside it.
    task automatic direct_check();
        fine_wr = 1'b1;
        dac_wr_data = 9'h0aa;
        step();
        fine_wr = 1'b0;
        step();
        check_dac('0);
        direct_mode = 1'b1;
        step();
        fine_wr = 1'b1;
        dac_wr_data = 9'h005;
        step();
        fine_wr = 1'b0;
        coarse_wr = 1'b1;
        dac_wr_data = 9'h003;
        step();
        coarse_wr = 1'b0;
        step();
        check_dac({8'h03, 9'h005});
    endtask

    // New target, then automatic mode resumes from the written codes.
    task automatic auto_check();
        target_value = 10'h048;
        target_load = 1'b1;
        step();
        target_load = 1'b0;
        step();
        check_val("black_target_level", 16'h0048, 16'(black_target_level));
        direct_mode = 1'b0;
        ccd_u.line(10'h050, 10'h000, 1, 1'b0, 0);
        done(10'h050);
        check_dac({8'h03, 9'h1fd});
    endtask

    // Short run ignored, then hot and cold pixels replaced by the previous one.
    task automatic limit_check();
        count_log2 = 3'h1;
        hot_limit = 10'h200;
        cold_limit = 10'h020;
        ccd_u.line(10'h100, 10'h000, 1, 1'b0, 0);
        repeat (12) step();
        check_val("black_estimate", 16'h0050, 16'(black_estimate));
        ccd_u.line(10'h048, 10'h3ff, 2, 1'b0, 2);
        done(10'h048);
        check_dac({8'h03, 9'h1fd});
        ccd_u.line(10'h044, 10'h001, 2, 1'b0, 0);
        done(10'h044);
        check_dac({8'h03, 9'h001});
    endtask

    // Half weight, then the fast first line of a frame.
    task automatic filter_check();
        count_log2 = 3'h0;
        weight_shift = 3'h1;
        ccd_u.line(10'h054, 10'h000, 1, 1'b0, 0);
        done(10'h04c);
        weight_shift = 3'h7;
        sof_fast_en = 1'b1;
        ccd_u.line(10'h3ff, 10'h000, 1, 1'b1, 0);
        done(10'h3ff);
        check_dac({8'h02, 9'h181});
    endtask

    // Main sequence: reset for eight cycles, then every scenario.
    initial
    begin
        repeat (8) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        step();
        reset_check();
        gain_check();
        direct_check();
        auto_check();
        limit_check();
        filter_check();
        results();
    end
endmodule
